// File: src/secded_codec.sv
module secded_codec
  import shared_mem_pkg::*;
(
  input wire logic [DATA_W-1:0] enc_data, // Word to be stored.
  output logic [CHK_W-1:0] enc_check, // Check byte for enc_data.
  input wire logic [CW_W-1:0] dec_word, // Stored word with its check byte on top.
  output logic [DATA_W-1:0] dec_data, // Word after correction.
  output logic [CHK_W-1:0] dec_check, // Check byte regenerated over dec_data.
  output logic [HAM_W-1:0] dec_syndrome, // Position of the altered bit.
  output logic dec_single, // Odd count of bits altered, taken as one.
  output logic dec_double // Two bits altered, data not repaired.
);

  // Hamming position of data bit idx: the idx-th position that is not a power of two.
  function automatic logic [HAM_W-1:0] pos_of(input int idx);
    int n;
    logic [HAM_W-1:0] r;
    n = 0;
    r = '0;
    for (int p = 3; p < (1 << HAM_W); p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == idx) begin
          r = HAM_W'(p);
        end
        n++;
      end
    end
    return r;
  endfunction

  logic [HAM_W-1:0] pos_tab [DATA_W];

  // The position table is a constant per data bit.
  for (genvar g = 0; g < DATA_W; g++) begin : g_pos
    localparam logic [HAM_W-1:0] POS = pos_of(g);
    assign pos_tab[g] = POS;
  end

  // Seven Hamming bits over the data, then overall parity on top for double detection.
  function automatic logic [CHK_W-1:0] calc_check(input logic [DATA_W-1:0] d, input logic [HAM_W-1:0] tab [DATA_W]);
    logic [HAM_W-1:0] h;
    h = '0;
    for (int j = 0; j < HAM_W; j++) begin
      for (int g = 0; g < DATA_W; g++) begin
        h[j] = h[j] ^ (d[g] & tab[g][j]);
      end
    end
    return {(^d) ^ (^h), h};
  endfunction

  logic [HAM_W-1:0] stored_ham;
  logic [HAM_W-1:0] fresh_ham;
  logic parity_bad;

  assign enc_check = calc_check(enc_data, pos_tab);

  assign fresh_ham = HAM_W'(calc_check(dec_word[DATA_W-1:0], pos_tab));
  assign stored_ham = dec_word[DATA_W+:HAM_W];
  assign dec_syndrome = fresh_ham ^ stored_ham;
  assign parity_bad = ^dec_word;
  // An odd count of flips is taken as one; an even nonzero syndrome means two.
  assign dec_single = parity_bad;
  assign dec_double = !parity_bad && (dec_syndrome != '0);

  for (genvar g = 0; g < DATA_W; g++) begin : g_fix
    assign dec_data[g] = dec_word[g] ^ (dec_single && (dec_syndrome == pos_tab[g]));
  end

  // The outgoing channel carries a fresh check byte so the receiver can check again.
  assign dec_check = calc_check(dec_data, pos_tab);

endmodule // secded_codec

// File: src/shared_mem_path.sv
// Operation
// - Generate 8-bit check code on every write.
// - Check every read; clean words pass unchanged.
// - Flip single altered bit back, deliver corrected.
// - Single error on a processor port sets memory error flag; I/O port errors are only logged.
// - Single error details go to error logger; of simultaneous errors only the lowest numbered requester is logged.
// - Multiple altered bits: no correction attempted; an odd count is taken as a single error and one bit is flipped.
// - Double error on a processor port sets memory error flag; I/O port errors are only logged.
// - Protect storage and channels in and out.
// - Sections and banks allow overlapping references.
// - Processors and I/O section share memory.
// - Four processor ports, each with fixed duty.
// - Bidirectional mode: block read and write concurrent.
// - Resolve bank conflicts fairly, all references complete.
module shared_mem_path
  import shared_mem_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic bidir_mode, // High lets block read and block write run together.
  input wire logic [NREQ-1:0] req, // Reference request per requester, held until acknowledged.
  input wire logic [NREQ-1:0] req_we, // Write intent, used by the exchange and I/O ports only.
  input wire logic [NREQ-1:0][ADDR_W-1:0] req_addr, // Word address per requester.
  input wire logic [NREQ-1:0][DATA_W-1:0] req_wdata, // Write data per requester.
  input wire logic [CW_W-1:0] fault_mask, // Diagnostic bits flipped in every stored word.
  input wire logic ctx_reload, // Saved context reloaded, clears the error flag.
  input wire logic flag_clear, // Software clear of the error flag.
  output logic [NREQ-1:0] req_ack_q, // One-cycle acknowledge of an accepted reference.
  output logic [NREQ-1:0] rd_valid_q, // One-cycle read data valid.
  output logic [NREQ-1:0][DATA_W-1:0] rd_data_q, // Read data after correction.
  output logic [NREQ-1:0][CHK_W-1:0] rd_check_q, // Check byte travelling with read data.
  output logic [NREQ-1:0] rd_corr_q, // Read carried a corrected single error.
  output logic [NREQ-1:0] rd_uncorr_q, // Read carried an uncorrectable double error.
  output logic mem_err_flag_q, // Memory error flag of the saved context.
  output logic log_valid_q, // One-cycle error log record.
  output logic [PORT_W-1:0] log_port_q, // Requester that saw the error.
  output logic [ADDR_W-1:0] log_addr_q, // Address of the failing word.
  output logic [HAM_W-1:0] log_syndrome_q, // Syndrome of the failing word.
  output logic log_double_q // Record is for a double error.
);

  // Request decode and arbitration.
  logic [NREQ-1:0] eff_we;
  logic [NREQ-1:0] elig;
  logic [NREQ-1:0] grant;
  logic [NREQ-1:0][BANK_W-1:0] bank_of;
  logic [NBANK-1:0] bank_hit;
  logic [NBANK-1:0][PORT_W-1:0] bank_win;

  // Bank occupancy and rotating priority state.
  logic [NBANK-1:0][BUSY_W-1:0] busy_cnt_q;
  logic [NBANK-1:0][PORT_W-1:0] rr_q;

  // Storage array, codecs and the read pipeline.
  logic [CW_W-1:0] mem_q [NWORDS];
  logic [NREQ-1:0][CHK_W-1:0] enc_check;
  logic [NREQ-1:0] rd_pend_q;
  logic [NREQ-1:0][CW_W-1:0] rd_word_q;
  logic [NREQ-1:0][ADDR_W-1:0] rd_addr_q;
  logic [NREQ-1:0][DATA_W-1:0] dec_data;
  logic [NREQ-1:0][CHK_W-1:0] dec_check;
  logic [NREQ-1:0][HAM_W-1:0] dec_syndrome;
  logic [NREQ-1:0] dec_single;
  logic [NREQ-1:0] dec_double;

  // Error flag and error log.
  logic [NREQ-1:0] err_seen;
  logic flag_set;
  logic block_rd_busy;
  logic log_hit;
  logic [PORT_W-1:0] log_idx;

  // One codec per requester: the encoder guards the inbound channel, the decoder the outbound.
  for (genvar i = 0; i < NREQ; i++) begin : g_codec
    secded_codec u_codec (
      .enc_data(req_wdata[i]),
      .enc_check(enc_check[i]),
      .dec_word(rd_word_q[i]),
      .dec_data(dec_data[i]),
      .dec_check(dec_check[i]),
      .dec_syndrome(dec_syndrome[i]),
      .dec_single(dec_single[i]),
      .dec_double(dec_double[i])
    );
  end

  // fixed port duties
  // Block read ports never write and the block write port never reads, whatever req_we says.
  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      if (ROLE_READ_ONLY[i]) begin
        eff_we[i] = 1'b0;
      end else if (ROLE_WRITE_ONLY[i]) begin
        eff_we[i] = 1'b1;
      end else begin
        eff_we[i] = req_we[i];
      end
      bank_of[i] = req_addr[i][BANK_W-1:0];
    end
  end

  // bidirectional mode gate
  // Outside bidirectional mode a pending block read holds the block write back.
  // The acknowledge cycle is excluded because the read port has already been served by then.
  assign block_rd_busy = (req[PORT_RD_A] && !req_ack_q[PORT_RD_A]) ||
                         (req[PORT_RD_B] && !req_ack_q[PORT_RD_B]);

  // A request is eligible when its bank is free and it is not in its acknowledge cycle.
  // The acknowledge is registered, so the request is still high in that cycle and must be masked.
  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      elig[i] = req[i] && !req_ack_q[i] && (busy_cnt_q[bank_of[i]] == RST_BUSY);
      if ((i == PORT_WR) && !bidir_mode && block_rd_busy) begin
        elig[i] = 1'b0;
      end
    end
  end

  // I/O section competes equally
  // Each bank grants at most one requester per cycle, starting from the one after its last winner,
  // so no requester can be starved by a busier neighbour on the same bank.
  always_comb begin
    int idx;
    idx = 0;
    grant = '0;
    bank_hit = '0;
    bank_win = '0;
    for (int b = 0; b < NBANK; b++) begin
      for (int k = 0; k < NREQ; k++) begin
        idx = int'(rr_q[b]) + k;
        if (idx >= NREQ) begin
          idx = idx - NREQ;
        end
        if (!bank_hit[b] && elig[idx] && (int'(bank_of[idx]) == b)) begin
          grant[idx] = 1'b1;
          bank_hit[b] = 1'b1;
          bank_win[b] = PORT_W'(idx);
        end
      end
    end
  end

  // Priority pointer moves past the winner of each bank.
  // Only banks that granted move their pointer, so an idle bank keeps its place in the rotation.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int b = 0; b < NBANK; b++) begin
        rr_q[b] <= RST_RR;
      end
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (bank_hit[b]) begin
          rr_q[b] <= (int'(bank_win[b]) == NREQ - 1) ? RST_RR : PORT_W'(bank_win[b] + 3'h1);
        end
      end
    end
  end

  // bank busy timing
  // Other banks stay free while one is busy, so references overlap across banks and sections.
  // The counter is loaded on the granting edge, so the bank takes its next grant BANK_BUSY_CYC cycles later.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int b = 0; b < NBANK; b++) begin
        busy_cnt_q[b] <= RST_BUSY;
      end
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (bank_hit[b]) begin
          busy_cnt_q[b] <= BUSY_W'(BANK_BUSY_CYC - 1);
        end else if (busy_cnt_q[b] != RST_BUSY) begin
          busy_cnt_q[b] <= busy_cnt_q[b] - 2'h1;
        end
      end
    end
  end

  // Acknowledge follows every grant by one edge.
  // A registered acknowledge keeps the outputs on flip-flops; the requester holds one cycle longer for it.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req_ack_q <= '0;
    end else begin
      req_ack_q <= grant;
    end
  end

  // storage and inbound channel
  // The fault mask lets diagnostics plant errors; it must be zero in normal service.
  // Two ports never write one word in one cycle, because each bank grants a single requester.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int w = 0; w < NWORDS; w++) begin
        mem_q[w] <= RST_WORD;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        if (grant[i] && eff_we[i]) begin
          mem_q[req_addr[i]] <= {enc_check[i], req_wdata[i]} ^ fault_mask;
        end
      end
    end
  end

  // Read capture: the raw stored word is held for the decoder in the following cycle.
  // Splitting the array read from the correction tree costs a cycle of latency but shortens the path.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_pend_q <= '0;
      for (int i = 0; i < NREQ; i++) begin
        rd_word_q[i] <= RST_WORD;
        rd_addr_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        rd_pend_q[i] <= grant[i] && !eff_we[i];
        if (grant[i] && !eff_we[i]) begin
          rd_word_q[i] <= mem_q[req_addr[i]];
          rd_addr_q[i] <= req_addr[i];
        end
      end
    end
  end

  // outbound channel check byte
  // After a double error the data is whatever the decoder leaves; only the status is reliable.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_valid_q <= '0;
      rd_corr_q <= '0;
      rd_uncorr_q <= '0;
      for (int i = 0; i < NREQ; i++) begin
        rd_data_q[i] <= RST_DATA;
        rd_check_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        rd_valid_q[i] <= rd_pend_q[i];
        rd_corr_q[i] <= rd_pend_q[i] && dec_single[i];
        rd_uncorr_q[i] <= rd_pend_q[i] && dec_double[i];
        if (rd_pend_q[i]) begin
          rd_data_q[i] <= dec_data[i];
          rd_check_q[i] <= dec_check[i];
        end
      end
    end
  end

  // Errors seen by processor ports belong to the processor context; I/O errors are only logged.
  // The I/O section has no saved context here, so flagging its errors would interrupt the wrong processor.
  assign err_seen = rd_pend_q & (dec_single | dec_double);
  assign flag_set = |(err_seen & PROC_PORTS);

  // sticky until reload or clear
  // A new error in the clearing cycle wins, so the interrupt request is never lost.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem_err_flag_q <= RST_FLAG;
    end else if (flag_set) begin
      mem_err_flag_q <= 1'b1;
    end else if (ctx_reload || flag_clear) begin
      mem_err_flag_q <= 1'b0;
    end
  end

  // Only one record leaves per cycle; the lowest numbered requester wins and others are not logged.
  // Simultaneous errors therefore under-report in the log; the error flag is still set if any of them came from a processor port.
  always_comb begin
    log_hit = 1'b0;
    log_idx = '0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (err_seen[i]) begin
        log_hit = 1'b1;
        log_idx = PORT_W'(i);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      log_valid_q <= 1'b0;
      log_port_q <= '0;
      log_addr_q <= '0;
      log_syndrome_q <= '0;
      log_double_q <= 1'b0;
    end else begin
      log_valid_q <= log_hit;
      if (log_hit) begin
        log_port_q <= log_idx;
        log_addr_q <= rd_addr_q[log_idx];
        log_syndrome_q <= dec_syndrome[log_idx];
        log_double_q <= dec_double[log_idx];
      end
    end
  end

endmodule // shared_mem_path

// File: src/shared_mem_pkg.sv
package shared_mem_pkg;

  // Word and check code geometry.
  localparam int DATA_W = 64;
  localparam int CHK_W = 8;
  localparam int HAM_W = 7;
  localparam int CW_W = DATA_W + CHK_W;
  // Position of the overall parity bit inside the check byte.
  localparam int PAR_BIT = 7;

  // Storage geometry: two sections of two banks, interleaved on the low address bits.
  localparam int ADDR_W = 6;
  localparam int NWORDS = 64;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int SECTION_BIT = 1;

  // Cycles a bank stays occupied by one reference, the granting cycle included.
  localparam int BANK_BUSY_CYC = 3;
  localparam int BUSY_W = 2;

  // Requesters: four processor ports with fixed duties, then the I/O section.
  localparam int NREQ = 5;
  localparam int PORT_W = 3;
  localparam int PORT_RD_A = 0;
  localparam int PORT_RD_B = 1;
  localparam int PORT_WR = 2;
  localparam int PORT_XCHG = 3;
  localparam int PORT_IO = 4;
  localparam logic [NREQ-1:0] ROLE_READ_ONLY = 5'h03;
  localparam logic [NREQ-1:0] ROLE_WRITE_ONLY = 5'h04;
  localparam logic [NREQ-1:0] PROC_PORTS = 5'h0f;

  // Values after reset.
  localparam logic RST_FLAG = 1'b0;
  localparam logic [BUSY_W-1:0] RST_BUSY = 2'h0;
  localparam logic [PORT_W-1:0] RST_RR = 3'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 64'h0000_0000_0000_0000;
  localparam logic [CW_W-1:0] RST_WORD = 72'h00_0000_0000_0000_0000;

endpackage : shared_mem_pkg

// File: tb/mem_requester.sv
module mem_requester
  import shared_mem_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [NREQ-1:0] start, // Begin a reference on these ports.
  input wire logic [NREQ-1:0] start_we, // Write intent per port.
  input wire logic [NREQ-1:0][ADDR_W-1:0] start_addr, // Address per port.
  input wire logic [NREQ-1:0][DATA_W-1:0] start_data, // Write data per port.
  input wire logic [NREQ-1:0] req_ack_q, // Acknowledge from memory.
  output logic [NREQ-1:0] req, // Held request.
  output logic [NREQ-1:0] req_we, // Write intent.
  output logic [NREQ-1:0][ADDR_W-1:0] req_addr, // Word address.
  output logic [NREQ-1:0][DATA_W-1:0] req_wdata // Write data.
);
  timeunit 1ns;
  timeprecision 1ns;
  // A request stands until the edge that samples its acknowledge; released address and data fields are
  // inverted so a stale address or word can never pass for a live one.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      req <= '0;
      req_we <= '0;
      req_addr <= '0;
      req_wdata <= '0;
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        if (req[i] && req_ack_q[i]) begin
          req[i] <= 1'b0;
          req_addr[i] <= ~req_addr[i];
          req_wdata[i] <= ~req_wdata[i];
        end else if (start[i] && !req[i]) begin
          req[i] <= 1'b1;
          req_we[i] <= start_we[i];
          req_addr[i] <= start_addr[i];
          req_wdata[i] <= start_data[i];
        end
      end
    end
  end
endmodule // mem_requester

// File: tb/shared_mem_path_props.sv
module shared_mem_path_props
  import shared_mem_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [NREQ-1:0] req, // Requests.
  input wire logic ctx_reload, // Context reload.
  input wire logic flag_clear, // Software flag clear.
  input wire logic [NREQ-1:0] req_ack_q, // Acknowledges.
  input wire logic [NREQ-1:0] rd_valid_q, // Read valid.
  input wire logic [NREQ-1:0] rd_corr_q, // Corrected single error.
  input wire logic [NREQ-1:0] rd_uncorr_q, // Double error.
  input wire logic mem_err_flag_q, // Error flag.
  input wire logic log_valid_q // Log record.
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so every check shares clock and reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_ack_single: assert property ((req_ack_q & $past(req_ack_q)) == '0)
    else $error("Acknowledge held for two cycles.");
  a_ack_needs_req: assert property ((req_ack_q & ~$past(req)) == '0)
    else $error("Acknowledge without a request.");
  a_read_latency: assert property ((rd_valid_q & ROLE_READ_ONLY) == ($past(req_ack_q) & ROLE_READ_ONLY))
    else $error("Read data not one cycle after acknowledge.");
  a_write_silent: assert property ((rd_valid_q & ROLE_WRITE_ONLY) == '0)
    else $error("Write port returned read data.");
  a_valid_cause: assert property ((rd_valid_q & ~$past(req_ack_q)) == '0)
    else $error("Read data without an accepted reference.");
  a_err_exclusive: assert property (((rd_corr_q & rd_uncorr_q) | ((rd_corr_q | rd_uncorr_q) & ~rd_valid_q)) == '0)
    else $error("Error marks inconsistent with read valid.");
  a_flag_sets: assert property (|((rd_corr_q | rd_uncorr_q) & PROC_PORTS) |-> mem_err_flag_q)
    else $error("Memory error did not set the flag.");
  a_flag_rise: assert property ($rose(mem_err_flag_q) |-> |((rd_corr_q | rd_uncorr_q) & PROC_PORTS))
    else $error("Flag rose without a memory error.");
  a_flag_sticky: assert property (mem_err_flag_q && !ctx_reload && !flag_clear |=> mem_err_flag_q)
    else $error("Flag dropped without a clear.");
  a_flag_cleared: assert property ((ctx_reload || flag_clear) ##1
    !(|((rd_corr_q | rd_uncorr_q) & PROC_PORTS)) |-> !mem_err_flag_q)
    else $error("Flag survived a clear.");
  a_log_pulse: assert property (log_valid_q == |(rd_corr_q | rd_uncorr_q))
    else $error("Log record does not match error reads.");
endmodule // shared_mem_path_props

bind shared_mem_path shared_mem_path_props i_props (.clk_sys, .reset, .req, .ctx_reload, .flag_clear, .req_ack_q,
  .rd_valid_q, .rd_corr_q, .rd_uncorr_q, .mem_err_flag_q, .log_valid_q);

// File: tb/shared_mem_path_test.sv
module shared_mem_path_test
  import shared_mem_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int wp; int rp; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} row_t;
  logic clk_sys = 1'b0, reset = 1'b1, bidir_mode = 1'b0, ctx_reload = 1'b0, flag_clear = 1'b0;
  logic [NREQ-1:0] start = '0, start_we = '0, req, req_we, req_ack_q, rd_valid_q, rd_corr_q, rd_uncorr_q;
  logic [NREQ-1:0][ADDR_W-1:0] sa = '0, req_addr;
  logic [NREQ-1:0][DATA_W-1:0] sd = '0, req_wdata, rd_data_q;
  logic [NREQ-1:0][CHK_W-1:0] rd_check_q;
  logic [CW_W-1:0] fault_mask = '0;
  logic mem_err_flag_q, log_valid_q, log_double_q;
  logic [PORT_W-1:0] log_port_q;
  logic [ADDR_W-1:0] log_addr_q;
  logic [HAM_W-1:0] log_syndrome_q;
  int fail_count = 0, n_tests = 0;
  row_t rows[4] = '{'{2, 0, 6'h05, 64'h0123_4567_89ab_cdef}, '{3, 1, 6'h2a, 64'hffff_ffff_ffff_ffff},
    '{4, 3, 6'h3f, 64'h8000_0000_0000_0001}, '{2, 4, 6'h10, 64'h5555_aaaa_0f0f_f0f0}};
  int bits[3] = '{0, 37, 63};

  // Free-running system clock.
  always #20 clk_sys = ~clk_sys;

  shared_mem_path i_dut (.clk_sys, .reset, .bidir_mode, .req, .req_we, .req_addr, .req_wdata, .fault_mask,
    .ctx_reload, .flag_clear, .req_ack_q, .rd_valid_q, .rd_data_q, .rd_check_q, .rd_corr_q, .rd_uncorr_q,
    .mem_err_flag_q, .log_valid_q, .log_port_q, .log_addr_q, .log_syndrome_q, .log_double_q);
  mem_requester i_req (.clk_sys, .reset, .start, .start_we, .start_addr(sa), .start_data(sd), .req_ack_q,
    .req, .req_we, .req_addr, .req_wdata);

  // Independent check byte: data bit g sits at the g-th non-power-of-two position from 3.
  function automatic logic [CHK_W-1:0] enc(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int g;
    c = '0;
    g = 0;
    for (int p = 3; g < DATA_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[6:0] ^= {7{d[g]}} & p[6:0];
        g++;
      end
    end
    c[PAR_BIT] = ^{d, c[6:0]};
    return c;
  endfunction

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Starts ports p together, waits a bounded time for every acknowledge, keeps the first pattern.
  task automatic run(input logic [NREQ-1:0] p, we, input logic [NREQ-1:0][ADDR_W-1:0] a,
                     input logic [NREQ-1:0][DATA_W-1:0] d, output logic [NREQ-1:0] first);
    logic [NREQ-1:0] seen;
    int n;
    seen = '0;
    first = '0;
    n = 0;
    @(posedge clk_sys);
    start <= p;
    start_we <= we;
    sa <= a;
    sd <= d;
    @(posedge clk_sys);
    start <= '0;
    while (seen != p && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (first == '0) first = req_ack_q;
      seen |= req_ack_q;
    end
    if (seen != p) begin
      check("acknowledge wait", seen, p);
      end_of_test();
    end
  endtask

  // Write through port wp, read back through rp, stop in the read valid cycle.
  task automatic wr_rd(input int wp, rp, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [NREQ-1:0] f;
    run(NREQ'(1) << wp, 5'h1c, {NREQ{a}}, {NREQ{d}}, f);
    run(NREQ'(1) << rp, 5'h00, {NREQ{a}}, {NREQ{d}}, f);
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    logic [NREQ-1:0] f;
    logic [CHK_W-1:0] syn;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("reset state", {mem_err_flag_q, log_valid_q, req_ack_q, rd_valid_q}, '0);
    foreach (rows[k]) begin
      wr_rd(rows[k].wp, rows[k].rp, rows[k].a, rows[k].d);
      check("read word", {rd_check_q[rows[k].rp], rd_data_q[rows[k].rp]}, {enc(rows[k].d), rows[k].d});
      check("read marks", {rd_valid_q[rows[k].rp], rd_corr_q[rows[k].rp], rd_uncorr_q[rows[k].rp]}, 3'b100);
    end
    $display("Test table done");
    foreach (bits[k]) begin
      @(posedge clk_sys) fault_mask <= CW_W'(1) << bits[k];
      wr_rd(2, 0, 6'h09, 64'hfeed_0000_1234_5678);
      syn = enc(DATA_W'(1) << bits[k]);
      check("corrected", {rd_data_q[0], rd_corr_q[0], rd_uncorr_q[0]}, {64'hfeed_0000_1234_5678, 2'b10});
      check("log", {log_valid_q, log_double_q, log_port_q, log_addr_q, log_syndrome_q}, {2'b10, 3'h0, 6'h09, syn[6:0]});
      repeat (3) @(posedge clk_sys);
      #1;
      check("flag held", mem_err_flag_q, 1'b1);
      @(posedge clk_sys) flag_clear <= 1'b1;
      @(posedge clk_sys) flag_clear <= 1'b0;
      #1;
      check("flag cleared", mem_err_flag_q, 1'b0);
    end
    $display("Test single errors done");
    @(posedge clk_sys) fault_mask <= 72'h00_0000_0100_0000_0008;
    wr_rd(3, 1, 6'h0e, 64'h0f0f_0f0f_0f0f_0f0f);
    check("double marks", {rd_corr_q[1], rd_uncorr_q[1], log_double_q}, 3'b011);
    check("double flag", mem_err_flag_q, 1'b1);
    @(posedge clk_sys) ctx_reload <= 1'b1;
    fault_mask <= '0;
    @(posedge clk_sys) ctx_reload <= 1'b0;
    #1;
    check("reload clears", mem_err_flag_q, 1'b0);
    $display("Test double error done");
    run(5'h05, 5'h04, {6'h00, 6'h00, 6'h01, 6'h00, 6'h00}, '0, f);
    check("serial read write", f, 5'h01);
    @(posedge clk_sys) bidir_mode <= 1'b1;
    run(5'h05, 5'h04, {6'h00, 6'h00, 6'h01, 6'h00, 6'h00}, '0, f);
    check("concurrent read write", f, 5'h05);
    run(5'h0b, 5'h00, {6'h00, 6'h0c, 6'h00, 6'h08, 6'h04}, '0, f);
    check("one grant per bank", $countones(f), 1);
    run(5'h1b, 5'h00, {6'h03, 6'h02, 6'h00, 6'h01, 6'h00}, '0, f);
    check("banks in parallel", f, 5'h1b);
    $display("Test ports and banks done");
    // An I/O port error is corrected and logged but leaves the processor flag alone.
    @(posedge clk_sys) fault_mask <= CW_W'(1) << 5;
    wr_rd(2, 4, 6'h11, 64'h0000_0000_0000_00ff);
    check("io corrected", {rd_data_q[4], rd_corr_q[4], rd_uncorr_q[4]}, {64'h0000_0000_0000_00ff, 2'b10});
    check("io log", {log_valid_q, log_double_q, log_port_q, log_addr_q}, {2'b10, 3'h4, 6'h11});
    check("io flag", mem_err_flag_q, 1'b0);
    // A new error in the clearing cycle wins over the clear.
    @(posedge clk_sys) flag_clear <= 1'b1;
    wr_rd(3, 0, 6'h12, 64'h0000_0000_0000_00ff);
    check("set beats clear", mem_err_flag_q, 1'b1);
    @(posedge clk_sys) flag_clear <= 1'b0;
    #1;
    check("clear after set", mem_err_flag_q, 1'b0);
    // A reset in mid-run drops the flag and zeroes the array.
    wr_rd(2, 1, 6'h13, 64'h0000_0000_0000_00ff);
    check("flag before reset", mem_err_flag_q, 1'b1);
    @(posedge clk_sys) reset <= 1'b1;
    fault_mask <= '0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("mid-run reset", {mem_err_flag_q, log_valid_q, req_ack_q, rd_valid_q}, '0);
    run(5'h02, 5'h00, {NREQ{6'h13}}, '0, f);
    @(posedge clk_sys);
    #1;
    check("read after reset", {rd_data_q[1], rd_valid_q[1], rd_corr_q[1]}, {64'h0000_0000_0000_0000, 2'b10});
    $display("Test awkward cases done");
    end_of_test();
  end
endmodule // shared_mem_path_test
